/* File: hw/imdt_defs.svh */
// Constants for the integer move decode and timing block.
// Assumes inclusion by bare name from hw/.
`ifndef IMDT_DEFS_SVH
`define IMDT_DEFS_SVH

`define IMDT_CORE_PER_BUS 2
`define IMDT_FAST_R 4'h2
`define IMDT_MISALIGN_CLK 8'h03
`define IMDT_DEP_CLK 8'h01
`define IMDT_INDEX_CLK 8'h01
`define IMDT_DISPIMM_CLK 8'h01
`define IMDT_INVAL_BUS 8'h01
`define IMDT_TLB0_BUS 8'h0D
`define IMDT_TLB1_BUS 8'h15
`define IMDT_TLB2_BUS 8'h1C
`define IMDT_TLB_CORE 8'h01
`define IMDT_BURST_EXTRA 8'h03
`define IMDT_LINE_BYTES 4'h0
`define IMDT_OP_TWO_BYTE 8'h0F
`define IMDT_CLK_ONE 8'h01
`define IMDT_CLK_TWO 8'h02
`define IMDT_CLK_THREE 8'h03
`define IMDT_CLK_FOUR 8'h04
`define IMDT_CLK_FIVE 8'h05

`endif

/* File: hw/imdt_pkg.sv */
// Types for the integer move decode and timing block.
// Assumes imdt_defs.svh supplies all numeric constants.
package imdt_pkg;

    typedef enum logic [3:0] {
        IMDT_OP_NONE = 4'h0,
        IMDT_OP_COPY_RR = 4'h1,
        IMDT_OP_COPY_MR = 4'h2,
        IMDT_OP_COPY_IMM = 4'h3,
        IMDT_OP_ZEXT = 4'h4,
        IMDT_OP_SEXT = 4'h5,
        IMDT_OP_STORE = 4'h6,
        IMDT_OP_REMOVE = 4'h7,
        IMDT_OP_SWAP = 4'h8,
        IMDT_OP_EALOAD = 4'h9,
        IMDT_OP_COPY_RM = 4'hA
    } imdt_op_t;

    typedef struct packed {
        logic [7:0] op0;
        logic [7:0] op1;
        logic [7:0] form;
        logic has_disp;
        logic has_imm;
        logic uses_index;
        logic [2:0] base_reg;
        logic misaligned;
        logic multi_read;
        logic addr_low16;
    } imdt_instr_t;

    typedef struct packed {
        logic ifetch_hit;
        logic data_hit;
        logic fill_busy;
        logic same_line;
        logic target_miss;
        logic target_dword_span;
        logic target_burst_span;
        logic bufs_full;
        logic [3:0] inval_cnt;
        logic tlb_miss;
        logic [1:0] tlb_dirty_cnt;
    } imdt_env_t;

    typedef struct packed {
        imdt_op_t op;
        logic full_width;
        logic has_mem;
        logic is_stack;
        logic [2:0] dest_reg;
        logic dest_valid;
        logic [7:0] base_clk;
    } imdt_dec_t;

    typedef struct packed {
        logic [3:0] r;
        logic [3:0] b;
        logic [3:0] w;
    } imdt_bus_t;

endpackage

/* File: hw/imdt_decode.sv */
// Combinational opcode decoder for the data-movement opcodes.
// Assumes the first opcode byte, second byte and form byte are presented together.
`timescale 1ns/1ps
`default_nettype none
`include "imdt_defs.svh"

module imdt_decode
    import imdt_pkg::*;
(
    input wire imdt_instr_t i_instr, // Instruction bytes and flags
    output imdt_dec_t o_dec // Decoded class and base count
);

    logic reg_mode;
    logic [2:0] sub_field;
    logic [2:0] rm_field;
    assign reg_mode = (i_instr.form[7:6] == 2'h3);
    assign sub_field = i_instr.form[5:3];
    assign rm_field = i_instr.form[2:0];

    always_comb begin
        o_dec = '0;
        o_dec.op = IMDT_OP_NONE;
        o_dec.full_width = i_instr.op0[0];
        o_dec.has_mem = !reg_mode;
        o_dec.dest_reg = sub_field;
        if (i_instr.op0[7:1] == 7'h44) begin
            o_dec.op = reg_mode ? IMDT_OP_COPY_RR : IMDT_OP_COPY_RM;
            o_dec.dest_reg = rm_field;
            o_dec.dest_valid = reg_mode;
            o_dec.base_clk = `IMDT_CLK_ONE;
        end else if (i_instr.op0[7:1] == 7'h45) begin
            o_dec.op = reg_mode ? IMDT_OP_COPY_RR : IMDT_OP_COPY_MR;
            o_dec.dest_valid = 1'b1;
            o_dec.base_clk = `IMDT_CLK_ONE;
        end else if (i_instr.op0[7:1] == 7'h63 && sub_field == 3'h0) begin
            o_dec.op = IMDT_OP_COPY_IMM;
            o_dec.dest_reg = rm_field;
            o_dec.dest_valid = reg_mode;
            o_dec.base_clk = `IMDT_CLK_ONE;
        end else if (i_instr.op0[7:4] == 4'hB) begin
            o_dec.op = IMDT_OP_COPY_IMM;
            o_dec.full_width = i_instr.op0[3];
            o_dec.has_mem = 1'b0;
            o_dec.dest_reg = i_instr.op0[2:0];
            o_dec.dest_valid = 1'b1;
            o_dec.base_clk = `IMDT_CLK_ONE;
        end else if (i_instr.op0 == `IMDT_OP_TWO_BYTE && i_instr.op1[7:4] == 4'hB
                     && i_instr.op1[2:1] == 2'h3) begin
            o_dec.op = i_instr.op1[3] ? IMDT_OP_SEXT : IMDT_OP_ZEXT;
            o_dec.full_width = i_instr.op1[0];
            o_dec.dest_valid = 1'b1;
            o_dec.base_clk = `IMDT_CLK_THREE;
        end else if (i_instr.op0[7:3] == 5'h0A) begin
            o_dec.op = IMDT_OP_STORE;
            o_dec.full_width = 1'b1;
            o_dec.has_mem = 1'b0;
            o_dec.is_stack = 1'b1;
            o_dec.base_clk = `IMDT_CLK_ONE;
        end else if (i_instr.op0 == 8'hFF && sub_field == 3'h6) begin
            o_dec.op = IMDT_OP_STORE;
            o_dec.is_stack = 1'b1;
            o_dec.base_clk = `IMDT_CLK_FOUR;
        end else if (i_instr.op0 == 8'h6A || i_instr.op0 == 8'h68) begin
            o_dec.op = IMDT_OP_STORE;
            o_dec.full_width = 1'b1;
            o_dec.has_mem = 1'b0;
            o_dec.is_stack = 1'b1;
            o_dec.base_clk = `IMDT_CLK_ONE;
        end else if (i_instr.op0[7:3] == 5'h0B) begin
            o_dec.op = IMDT_OP_REMOVE;
            o_dec.full_width = 1'b1;
            o_dec.has_mem = 1'b0;
            o_dec.is_stack = 1'b1;
            o_dec.dest_reg = i_instr.op0[2:0];
            o_dec.dest_valid = 1'b1;
            o_dec.base_clk = `IMDT_CLK_ONE;
        end else if (i_instr.op0 == 8'h8F && sub_field == 3'h0) begin
            o_dec.op = IMDT_OP_REMOVE;
            o_dec.is_stack = 1'b1;
            o_dec.dest_reg = rm_field;
            o_dec.dest_valid = reg_mode;
            o_dec.base_clk = reg_mode ? `IMDT_CLK_FOUR : `IMDT_CLK_FIVE;
        end else if (i_instr.op0[7:1] == 7'h43) begin
            o_dec.op = IMDT_OP_SWAP;
            o_dec.dest_valid = 1'b1;
            o_dec.base_clk = reg_mode ? `IMDT_CLK_THREE : `IMDT_CLK_FIVE;
        end else if (i_instr.op0[7:3] == 5'h12) begin
            o_dec.op = IMDT_OP_SWAP;
            o_dec.full_width = 1'b1;
            o_dec.has_mem = 1'b0;
            o_dec.dest_reg = i_instr.op0[2:0];
            o_dec.dest_valid = 1'b1;
            o_dec.base_clk = `IMDT_CLK_THREE;
        end else if (i_instr.op0 == 8'h8D) begin
            o_dec.op = IMDT_OP_EALOAD;
            o_dec.full_width = 1'b1;
            o_dec.has_mem = 1'b0;
            o_dec.dest_valid = 1'b1;
            o_dec.base_clk = i_instr.uses_index ? `IMDT_CLK_TWO : `IMDT_CLK_ONE;
        end
    end

endmodule
`default_nettype wire

/* File: hw/imdt_bus_cost.sv */
// Bus-clock penalty calculator for misses, jumps, writes, invalidates and TLB walks.
// Assumes the bus profile is held steady while an instruction is scored.
`timescale 1ns/1ps
`default_nettype none
`include "imdt_defs.svh"

module imdt_bus_cost
    import imdt_pkg::*;
(
    input wire imdt_bus_t i_bus, // Bus r-b-w profile
    input wire imdt_env_t i_env, // Cache and bus conditions
    input wire logic i_has_mem, // Instruction touches data memory
    input wire logic i_is_write, // Instruction writes memory
    input wire logic i_multi_read, // Reads several consecutive items
    input wire logic i_addr_low16, // First access on a 16-byte boundary
    output logic [7:0] o_bus_clk, // Total bus-clock penalty
    output logic o_tlb_core // Extra core clock from a TLB walk
);

    function automatic logic [7:0] fill_cost(input imdt_bus_t p);
        fill_cost = 8'(p.r) + 8'(p.b) * `IMDT_BURST_EXTRA;
    endfunction

    always_comb begin
        o_bus_clk = 8'h00;
        if (!i_env.ifetch_hit || (i_has_mem && !i_env.data_hit)) begin
            o_bus_clk = fill_cost(i_bus);
            o_bus_clk = o_bus_clk + 8'(i_bus.r) - 8'(`IMDT_FAST_R);
            if (i_multi_read && !i_addr_low16) begin
                o_bus_clk = o_bus_clk + fill_cost(i_bus);
            end
        end
        if (i_env.target_miss) begin
            o_bus_clk = o_bus_clk + 8'(i_bus.r);
            if (i_env.target_dword_span) begin
                o_bus_clk = o_bus_clk + 8'(i_bus.b) * `IMDT_BURST_EXTRA;
            end
            if (i_env.target_burst_span) begin
                o_bus_clk = o_bus_clk + fill_cost(i_bus);
            end
        end
        if (i_is_write && i_env.bufs_full) begin
            o_bus_clk = o_bus_clk + 8'(i_bus.w);
        end
        o_bus_clk = o_bus_clk + 8'(i_env.inval_cnt) * `IMDT_INVAL_BUS;
        if (i_env.tlb_miss) begin
            case (i_env.tlb_dirty_cnt)
                2'h0: o_bus_clk = o_bus_clk + `IMDT_TLB0_BUS;
                2'h1: o_bus_clk = o_bus_clk + `IMDT_TLB1_BUS;
                default: o_bus_clk = o_bus_clk + `IMDT_TLB2_BUS;
            endcase
        end
        o_tlb_core = i_env.tlb_miss;
    end

endmodule
`default_nettype wire

/* File: hw/imdt_top.sv */
// Decode and core-clock cost model for integer data-movement instructions.
// Assumes one instruction offered per valid pulse from same-clock logic.
//
// Behaviour
// - resume flag suppresses breakpoint at return address
// - listed counts assume hits; misses add penalty
// - bus cost given as r-b-w; fastest 2-1-2
// - slower bus adds r minus two
// - misaligned access adds three core clocks
// - fill in progress stalls dependent access
// - base from previous destination adds one
// - index register may add one clock
// - jump target miss adds r, 3b, r+3b
// - write clocks only when buffers full
// - displacement plus immediate may add one
// - each contending invalidate adds one bus clock
// - TLB miss adds 13/21/28 plus one
// - unaligned multi-read may add extra fill
// - register copy forms take one clock
// - immediate copy forms take one clock
// - extending copies take three clocks
// - stack remove forms with their counts
// - swap forms with their counts
// - address load one or two clocks
// - memory-to-register copy takes one clock
`timescale 1ns/1ps
`default_nettype none
`include "imdt_defs.svh"

module imdt_top
    import imdt_pkg::*;
(
    input wire logic I_CLOCK, // Core clock
    input wire logic I_RST, // Asynchronous reset, active high
    input wire logic I_VALID, // Instruction offered
    input wire imdt_instr_t I_INSTR, // Instruction bytes and flags
    input wire imdt_env_t I_ENV, // Cache and bus conditions
    input wire imdt_bus_t I_BUS, // Bus r-b-w profile
    input wire logic I_RESUME_FLAG, // resume_flag at handler return
    input wire logic I_BKPT_HIT, // Execution breakpoint matches
    input wire logic I_FILL_DONE, // Line fill completed
    output logic O_DONE, // Instruction costed
    output imdt_op_t O_OP, // Decoded class
    output logic O_FULL_WIDTH, // Full-width operands
    output logic O_ILLEGAL, // Opcode not in this group
    output logic [7:0] O_CORE_CLK, // Total core clocks
    output logic [7:0] O_BUS_CLK, // Bus-clock penalty
    output logic O_BKPT_FAULT, // Raise execution breakpoint
    output logic O_STALL // Waiting on a line fill
);

    // ------------------------------------------------------------
    // Decode and bus cost
    // ------------------------------------------------------------
    imdt_dec_t dec;
    logic [7:0] bus_clk;
    logic tlb_core;
    logic is_write;

    imdt_decode u_decode (
        .i_instr(I_INSTR),
        .o_dec(dec)
    );

    // Every stack store writes the stack, other forms only with a memory operand
    assign is_write = (dec.op == IMDT_OP_STORE)
                      || (dec.has_mem && (dec.op == IMDT_OP_COPY_RM
                                          || dec.op == IMDT_OP_COPY_IMM
                                          || dec.op == IMDT_OP_REMOVE
                                          || dec.op == IMDT_OP_SWAP));

    imdt_bus_cost u_bus_cost (
        .i_bus(I_BUS),
        .i_env(I_ENV),
        .i_has_mem(dec.has_mem),
        .i_is_write(is_write),
        .i_multi_read(I_INSTR.multi_read),
        .i_addr_low16(I_INSTR.addr_low16),
        .o_bus_clk(bus_clk),
        .o_tlb_core(tlb_core)
    );

    // ------------------------------------------------------------
    // Fill synchroniser and stall
    // ------------------------------------------------------------
    logic fill_meta_r;
    logic fill_done_r;
    logic fill_seen_r;
    logic fill_rise;
    logic stall_r;
    logic fill_wait;

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            fill_meta_r <= 1'b0;
            fill_done_r <= 1'b0;
            fill_seen_r <= 1'b0;
        end else begin
            fill_meta_r <= I_FILL_DONE;
            fill_done_r <= fill_meta_r;
            fill_seen_r <= fill_done_r;
        end
    end

    // Release only on a fresh completion; the level left by the last fill
    // would otherwise free the next stall before its own fill ends
    assign fill_rise = fill_done_r && !fill_seen_r;

    assign fill_wait = I_ENV.fill_busy && ((dec.has_mem && !I_ENV.data_hit)
                                           || I_ENV.same_line);

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            stall_r <= 1'b0;
        end else if (stall_r) begin
            stall_r <= !fill_rise;
        end else if (I_VALID && fill_wait) begin
            stall_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Address dependency tracking
    // ------------------------------------------------------------
    logic [2:0] prev_dest_r;
    logic prev_dest_valid_r;
    logic prev_stack_r;
    logic accept;
    logic dep_hit;

    assign accept = I_VALID && !stall_r && !fill_wait;
    assign dep_hit = dec.has_mem && prev_dest_valid_r && (prev_dest_r == I_INSTR.base_reg)
                     && !(dec.is_stack && prev_stack_r);

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            prev_dest_r <= 3'h0;
            prev_dest_valid_r <= 1'b0;
            prev_stack_r <= 1'b0;
        end else if (accept) begin
            prev_dest_r <= dec.dest_reg;
            prev_dest_valid_r <= dec.dest_valid;
            prev_stack_r <= dec.is_stack;
        end
    end

    // ------------------------------------------------------------
    // Core clock total
    // ------------------------------------------------------------
    logic [7:0] core_nxt;

    always_comb begin
        core_nxt = dec.base_clk;
        if (I_INSTR.misaligned && dec.has_mem) begin
            core_nxt = core_nxt + `IMDT_MISALIGN_CLK;
        end
        if (dep_hit) begin
            core_nxt = core_nxt + `IMDT_DEP_CLK;
        end
        if (I_INSTR.uses_index && dec.has_mem) begin
            core_nxt = core_nxt + `IMDT_INDEX_CLK;
        end
        if (I_INSTR.has_disp && I_INSTR.has_imm) begin
            core_nxt = core_nxt + `IMDT_DISPIMM_CLK;
        end
        if (tlb_core) begin
            core_nxt = core_nxt + `IMDT_TLB_CORE;
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_DONE <= 1'b0;
            O_OP <= IMDT_OP_NONE;
            O_FULL_WIDTH <= 1'b0;
            O_ILLEGAL <= 1'b0;
            O_CORE_CLK <= 8'h00;
            O_BUS_CLK <= 8'h00;
        end else begin
            O_DONE <= accept;
            if (accept) begin
                O_OP <= dec.op;
                O_FULL_WIDTH <= dec.full_width;
                O_ILLEGAL <= (dec.op == IMDT_OP_NONE);
                O_CORE_CLK <= core_nxt;
                O_BUS_CLK <= bus_clk;
            end
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_BKPT_FAULT <= 1'b0;
        end else begin
            O_BKPT_FAULT <= accept && I_BKPT_HIT && !I_RESUME_FLAG;
        end
    end

    assign O_STALL = stall_r;

endmodule
`default_nettype wire

/* File: testbench/imdt_mem_model.sv */
// Far-side model: external bus profile and cache line fill completion.
// Assumes the core raises its stall flag while it waits on a fill.
`timescale 1ns/1ps
`default_nettype none

module imdt_mem_model
    import imdt_pkg::*;
#(
    parameter int FILL_LAT = 4
)(
    input wire logic i_clk, // Core clock
    input wire logic i_rst, // Asynchronous reset, active high
    input wire logic i_stall, // Core waits on a fill
    input wire logic i_slow, // Select the slower bus
    output imdt_bus_t o_bus, // Bus r-b-w profile
    output logic o_fill_done // Line fill finished
);
    logic [3:0] cnt_r;

    // Fastest profile 2-1-2, or a slower one with wait states
    assign o_bus = i_slow ? imdt_bus_t'{r: 4'h4, b: 4'h1, w: 4'h3}
                          : imdt_bus_t'{r: 4'h2, b: 4'h1, w: 4'h2};

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= 4'h0;
            o_fill_done <= 1'b0;
        end else if (!i_stall) begin
            cnt_r <= 4'h0;
            o_fill_done <= 1'b0;
        end else if (cnt_r == FILL_LAT[3:0]) begin
            o_fill_done <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule

`default_nettype wire

/* File: testbench/imdt_top_chk.sv */
// Concurrent checks on the ports of the move decode and timing block.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module imdt_top_chk
    import imdt_pkg::*;
(
    input wire logic I_CLOCK, // Core clock
    input wire logic I_RST, // Reset
    input wire logic I_VALID, // Offer
    input wire imdt_instr_t I_INSTR, // Instruction
    input wire imdt_env_t I_ENV, // Conditions
    input wire imdt_bus_t I_BUS, // Bus profile
    input wire logic I_RESUME_FLAG, // Resume flag
    input wire logic I_BKPT_HIT, // Breakpoint match
    input wire logic I_FILL_DONE, // Fill done
    input wire logic O_DONE, // Costed
    input wire imdt_op_t O_OP, // Class
    input wire logic O_FULL_WIDTH, // Width
    input wire logic O_ILLEGAL, // Not in group
    input wire logic [7:0] O_CORE_CLK, // Core clocks
    input wire logic [7:0] O_BUS_CLK, // Bus clocks
    input wire logic O_BKPT_FAULT, // Breakpoint fault
    input wire logic O_STALL // Fill wait
);
    wire logic acc;
    wire logic calm;

    assign acc = I_VALID && !O_STALL && !I_ENV.fill_busy;
    assign calm = I_ENV.ifetch_hit && I_ENV.data_hit && !I_ENV.target_miss
        && !I_ENV.bufs_full && I_ENV.inval_cnt == 4'h0 && !I_ENV.tlb_miss;

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    a_done_accept: assert property (acc |=> O_DONE)
        else $error("done missing after accept");
    a_done_cause: assert property (O_DONE |-> $past(I_VALID) && !$past(O_STALL))
        else $error("done without an accepted offer");
    a_fill_block: assert property (I_VALID && !O_STALL && I_ENV.fill_busy && I_ENV.same_line
        |=> O_STALL && !O_DONE)
        else $error("access to filling line not stalled");
    a_stall_release: assert property (I_FILL_DONE && O_STALL |-> ##[1:4] !O_STALL)
        else $error("stall held after fill done");
    a_bkpt_raise: assert property (acc && I_BKPT_HIT && !I_RESUME_FLAG |=> O_BKPT_FAULT)
        else $error("breakpoint fault missing");
    a_bkpt_quiet: assert property (O_BKPT_FAULT |-> $past(I_BKPT_HIT && !I_RESUME_FLAG))
        else $error("breakpoint fault not suppressed");
    a_copy_rr: assert property (acc && calm && I_INSTR.op0[7:2] == 6'h22
        && I_INSTR.form[7:6] == 2'h3 && !I_INSTR.has_disp
        |=> O_OP == IMDT_OP_COPY_RR && O_CORE_CLK == 8'h01 && O_FULL_WIDTH == $past(I_INSTR.op0[0]))
        else $error("register copy decoded wrongly");
    a_ext_kind: assert property (acc && I_INSTR.op0 == 8'h0F && I_INSTR.op1[7:4] == 4'hB
        && I_INSTR.op1[2:1] == 2'h3
        |=> O_OP == ($past(I_INSTR.op1[3]) ? IMDT_OP_SEXT : IMDT_OP_ZEXT))
        else $error("extension kind wrong");
    a_bus_quiet: assert property (acc && calm |=> O_BUS_CLK == 8'h00)
        else $error("bus penalty on all hits");
endmodule

bind imdt_top imdt_top_chk chk (
    .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_VALID(I_VALID), .I_INSTR(I_INSTR), .I_ENV(I_ENV),
    .I_BUS(I_BUS), .I_RESUME_FLAG(I_RESUME_FLAG), .I_BKPT_HIT(I_BKPT_HIT),
    .I_FILL_DONE(I_FILL_DONE), .O_DONE(O_DONE), .O_OP(O_OP), .O_FULL_WIDTH(O_FULL_WIDTH),
    .O_ILLEGAL(O_ILLEGAL), .O_CORE_CLK(O_CORE_CLK), .O_BUS_CLK(O_BUS_CLK),
    .O_BKPT_FAULT(O_BKPT_FAULT), .O_STALL(O_STALL)
);

`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the move decode and timing block.
// Assumes the far-side model drives fill completion and bus profile.
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import imdt_pkg::*;
;
    logic I_CLOCK, I_RST, I_VALID, I_RESUME_FLAG, I_BKPT_HIT, slow;
    wire logic I_FILL_DONE;
    wire imdt_bus_t I_BUS;
    imdt_instr_t I_INSTR;
    imdt_env_t I_ENV;
    logic O_DONE, O_FULL_WIDTH, O_ILLEGAL, O_BKPT_FAULT, O_STALL;
    imdt_op_t O_OP;
    logic [7:0] O_CORE_CLK, O_BUS_CLK;
    int miscompares = 0;
    int n_checks = 0;

    imdt_top uut (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_VALID(I_VALID), .I_INSTR(I_INSTR),
        .I_ENV(I_ENV), .I_BUS(I_BUS), .I_RESUME_FLAG(I_RESUME_FLAG), .I_BKPT_HIT(I_BKPT_HIT),
        .I_FILL_DONE(I_FILL_DONE), .O_DONE(O_DONE), .O_OP(O_OP), .O_FULL_WIDTH(O_FULL_WIDTH),
        .O_ILLEGAL(O_ILLEGAL), .O_CORE_CLK(O_CORE_CLK), .O_BUS_CLK(O_BUS_CLK),
        .O_BKPT_FAULT(O_BKPT_FAULT), .O_STALL(O_STALL));
    imdt_mem_model u_mem (.i_clk(I_CLOCK), .i_rst(I_RST), .i_stall(O_STALL), .i_slow(slow),
        .o_bus(I_BUS), .o_fill_done(I_FILL_DONE));

    initial begin
        I_CLOCK = 1'b0;
        forever #25 I_CLOCK = ~I_CLOCK;
    end

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic imdt_instr_t mk(input logic [7:0] a, input logic [7:0] b,
        input logic [7:0] f);
        imdt_instr_t t;
        t = '0;
        t.op0 = a;
        t.op1 = b;
        t.form = f;
        t.base_reg = 3'h7;
        return t;
    endfunction

    function automatic imdt_env_t hit();
        imdt_env_t e;
        e = '0;
        e.ifetch_hit = 1'b1;
        e.data_hit = 1'b1;
        return e;
    endfunction

    task automatic offer(input imdt_instr_t t, input imdt_env_t e, input logic [7:0] core,
        input logic [7:0] bus);
        @(negedge I_CLOCK);
        I_INSTR = t;
        I_ENV = e;
        I_VALID = 1'b1;
        @(negedge I_CLOCK);
        I_VALID = 1'b0;
        chk({7'h0, O_DONE}, 8'h01);
        chk(O_CORE_CLK, core);
        chk(O_BUS_CLK, bus);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_table();
        logic [31:0] tab [22] = '{32'h88_00_C1_11, 32'h8B_00_C1_11, 32'hC6_00_C0_31,
            32'hC7_00_C1_31, 32'hB0_00_00_31, 32'hB8_00_00_31, 32'h0F_B6_C1_43,
            32'h0F_B7_C1_43, 32'h0F_BE_C1_53, 32'h0F_BF_C1_53, 32'h50_00_00_61,
            32'hFF_00_F0_64, 32'hFF_00_37_64, 32'h6A_00_00_61, 32'h68_00_00_61,
            32'h58_00_00_71, 32'h8F_00_C0_74, 32'h8F_00_07_75, 32'h87_00_C1_83,
            32'h86_00_07_85, 32'h91_00_00_83, 32'h8D_00_07_91};
        // Expected operand width of each entry, entry 0 in bit 0
        logic [21:0] fw = 22'h37FEAA;
        foreach (tab[i]) begin
            offer(mk(tab[i][31:24], tab[i][23:16], tab[i][15:8]), hit(), {4'h0, tab[i][3:0]},
                8'h00);
            chk({4'h0, O_OP}, {4'h0, tab[i][7:4]});
            chk({7'h0, O_FULL_WIDTH}, {7'h0, fw[i]});
            chk({7'h0, O_ILLEGAL}, 8'h00);
        end
        offer(mk(8'h00, 8'h00, 8'hC0), hit(), 8'h00, 8'h00);
        chk({7'h0, O_ILLEGAL}, 8'h01);
        chk({4'h0, O_OP}, {4'h0, IMDT_OP_NONE});
        $display("decode table test ended");
    endtask

    task automatic t_mem();
        imdt_instr_t t;
        t = mk(8'h8B, 8'h00, 8'h07);
        offer(t, hit(), 8'h01, 8'h00);
        t.misaligned = 1'b1;
        offer(t, hit(), 8'h04, 8'h00);
        offer(mk(8'h8B, 8'h00, 8'hC1), hit(), 8'h01, 8'h00);
        t.misaligned = 1'b0;
        t.base_reg = 3'h0;
        offer(t, hit(), 8'h02, 8'h00);
        t = mk(8'h8D, 8'h00, 8'h04);
        t.uses_index = 1'b1;
        offer(t, hit(), 8'h02, 8'h00);
        t = mk(8'hC7, 8'h00, 8'h87);
        t.has_disp = 1'b1;
        t.has_imm = 1'b1;
        offer(t, hit(), 8'h02, 8'h00);
        $display("memory form test ended");
    endtask

    task automatic t_bus();
        imdt_instr_t t;
        imdt_env_t e;
        logic [7:0] tlb [3] = '{8'h0D, 8'h15, 8'h1C};
        t = mk(8'h8B, 8'h00, 8'hC1);
        e = hit();
        e.ifetch_hit = 1'b0;
        offer(t, e, 8'h01, 8'h05);
        slow = 1'b1;
        offer(t, e, 8'h01, 8'h09);
        slow = 1'b0;
        e = hit();
        e.target_miss = 1'b1;
        e.target_dword_span = 1'b1;
        e.target_burst_span = 1'b1;
        offer(t, e, 8'h01, 8'h0A);
        e = hit();
        e.inval_cnt = 4'h3;
        offer(t, e, 8'h01, 8'h03);
        for (int k = 0; k < 3; k++) begin
            e = hit();
            e.tlb_miss = 1'b1;
            e.tlb_dirty_cnt = k[1:0];
            offer(t, e, 8'h02, tlb[k]);
        end
        e = hit();
        e.bufs_full = 1'b1;
        offer(t, e, 8'h01, 8'h00);
        offer(mk(8'h89, 8'h00, 8'h07), e, 8'h01, 8'h02);
        offer(mk(8'hC7, 8'h00, 8'h07), e, 8'h01, 8'h02);
        t = mk(8'h8B, 8'h00, 8'h07);
        t.multi_read = 1'b1;
        e = hit();
        e.data_hit = 1'b0;
        offer(t, e, 8'h01, 8'h0A);
        t.addr_low16 = 1'b1;
        offer(t, e, 8'h01, 8'h05);
        $display("bus penalty test ended");
    endtask

    task automatic t_stall();
        imdt_env_t e;
        int n;
        e = hit();
        e.fill_busy = 1'b1;
        e.same_line = 1'b1;
        @(negedge I_CLOCK);
        I_INSTR = mk(8'h8B, 8'h00, 8'hC1);
        I_ENV = e;
        I_VALID = 1'b1;
        @(negedge I_CLOCK);
        chk({6'h0, O_STALL, O_DONE}, 8'h02);
        n = 0;
        while (O_STALL === 1'b1 && n < 50) begin
            @(negedge I_CLOCK);
            n++;
        end
        I_VALID = 1'b0;
        chk({6'h0, O_STALL, O_DONE}, 8'h00);
        offer(mk(8'h8B, 8'h00, 8'hC1), hit(), 8'h01, 8'h00);
        $display("fill stall test ended");
    endtask

    task automatic t_bkpt();
        I_BKPT_HIT = 1'b1;
        I_RESUME_FLAG = 1'b1;
        offer(mk(8'h8B, 8'h00, 8'hC1), hit(), 8'h01, 8'h00);
        chk({7'h0, O_BKPT_FAULT}, 8'h00);
        I_RESUME_FLAG = 1'b0;
        offer(mk(8'h8B, 8'h00, 8'hC1), hit(), 8'h01, 8'h00);
        chk({7'h0, O_BKPT_FAULT}, 8'h01);
        I_BKPT_HIT = 1'b0;
        $display("breakpoint test ended");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        I_RST = 1'b1;
        I_VALID = 1'b0;
        I_INSTR = '0;
        I_ENV = '0;
        I_RESUME_FLAG = 1'b0;
        I_BKPT_HIT = 1'b0;
        slow = 1'b0;
        repeat (10) @(posedge I_CLOCK);
        @(negedge I_CLOCK);
        I_RST = 1'b0;
        t_table();
        t_mem();
        t_bus();
        t_stall();
        t_bkpt();
        test_done();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge I_CLOCK);
        miscompares++;
        test_done();
    end
endmodule

`default_nettype wire
